// File: inc/crf_regs.vh
/*
 * register selector codes, condition flag bit positions, reset values
 * and width constants for the processor register file.
 * assumes: included by bare name from the design files.
 */
`ifndef CRF_REGS_VH
`define CRF_REGS_VH

// ----------------------------------------
// register selectors (internal, not memory mapped)
// ----------------------------------------
`define CRF_SEL_ACCH  3'h0
`define CRF_SEL_ACCL  3'h1
`define CRF_SEL_DACC  3'h2
`define CRF_SEL_PTR1  3'h3
`define CRF_SEL_PTR2  3'h4
`define CRF_SEL_SP    3'h5
`define CRF_SEL_PC    3'h6
`define CRF_SEL_FLAGS 3'h7

// ----------------------------------------
// condition flag bit positions
// ----------------------------------------
`define CRF_F_STOPLOCK 7
`define CRF_F_HPMASK   6
`define CRF_F_HALF     5
`define CRF_F_IMASK    4
`define CRF_F_NEG      3
`define CRF_F_ZERO     2
`define CRF_F_OVF      1
`define CRF_F_CARRY    0

// masks set, stop locked, result flags clear
`define CRF_FLAGS_RST  8'hd0

// ----------------------------------------
// alu operations
// ----------------------------------------
`define CRF_OP_ADD    3'h0
`define CRF_OP_ADC    3'h1
`define CRF_OP_SUB    3'h2
`define CRF_OP_SBC    3'h3
`define CRF_OP_DAA    3'h4
`define CRF_OP_PASS   3'h5

// ----------------------------------------
// index base selectors
// ----------------------------------------
`define CRF_BASE_P1   2'h0
`define CRF_BASE_P2   2'h1
`define CRF_BASE_SP   2'h2
`define CRF_BASE_PC   2'h3

// offset source selectors
`define CRF_OFS_CONST 2'h0
`define CRF_OFS_ACCH  2'h1
`define CRF_OFS_ACCL  2'h2
`define CRF_OFS_DACC  2'h3

`define CRF_QUEUE_MIN 3
`define CRF_EXT_W     20

`endif

// File: verilog/crf_alu.v
/*
 * arithmetic unit for the register file: add, add with carry,
 * subtract, subtract with borrow, decimal adjust and pass-through,
 * at 8 or 16 bit width (decimal adjust at 8 only), with half-carry, negative, zero, overflow and
 * carry results.
 * assumes: purely combinational; the caller decides when to latch flags.
 */
`timescale 1ns/100ps
`include "crf_regs.vh"

module crf_alu #(
	parameter EXT_W = `CRF_EXT_W
) (
	// operation
	input  wire [2:0]       op,
	input  wire             wide,
	input  wire [15:0]      opa,
	input  wire [15:0]      opb,
	input  wire             c_in,
	input  wire             h_in,
	// result
	output reg  [15:0]      res,
	output reg  [EXT_W-1:0] res_ext,
	output reg              h_out,
	output reg              n_out,
	output reg              z_out,
	output reg              v_out,
	output reg              c_out
);

	reg [16:0] sum;
	reg [4:0]  nib;
	reg [7:0]  adj;
	reg [8:0]  dsum;
	reg        cin_eff;
	reg        sub;
	reg [15:0] bb;
	reg        sa;
	reg        sb;
	reg        sr;

	always @* begin
		sum     = 17'h00000;
		nib     = 5'h00;
		adj     = 8'h00;
		dsum    = 9'h000;
		sub     = (op == `CRF_OP_SUB) || (op == `CRF_OP_SBC);
		cin_eff = ((op == `CRF_OP_ADC) || (op == `CRF_OP_SBC)) ? c_in
			: 1'b0;
		bb      = sub ? ~opb : opb;
		res     = 16'h0000;
		h_out   = h_in;
		c_out   = c_in;
		v_out   = 1'b0;
		case (op)
		`CRF_OP_ADD, `CRF_OP_ADC, `CRF_OP_SUB, `CRF_OP_SBC: begin
			// subtract is a + ~b + 1, borrow is the inverted carry
			sum = {1'b0, opa} + {1'b0, bb} + {16'h0000, sub ^ cin_eff};
			if (!wide) begin
				sum[8] = opa[7:0] + bb[7:0] + {7'h00, sub ^ cin_eff}
					> 9'h0ff;
				sum[16] = 1'b0;
			end
			res = wide ? sum[15:0] : {8'h00, sum[7:0]};
			nib = {1'b0, opa[3:0]} + {1'b0, opb[3:0]}
				+ {4'h0, cin_eff};
			if (!sub && !wide)
				h_out = nib[4]; // RQ9
			c_out = (wide ? sum[16] : sum[8]) ^ sub; // RQ15
		end
		`CRF_OP_DAA: begin
			// correction from half-carry and carry
			adj = 8'h00;
			if (h_in || (opa[3:0] > 4'h9))
				adj[3:0] = 4'h6; // RQ10
			if (c_in || (opa[7:4] > 4'h9) ||
				((opa[7:4] == 4'h9) && (opa[3:0] > 4'h9)))
				adj[7:4] = 4'h6; // RQ10
			dsum  = {1'b0, opa[7:0]} + {1'b0, adj};
			res   = {8'h00, dsum[7:0]};
			c_out = c_in | dsum[8]; // RQ10
		end
		`CRF_OP_PASS: begin
			res = wide ? opb : {8'h00, opb[7:0]};
		end
		default: begin
			res = 16'h0000;
		end
		endcase
		sa = wide ? opa[15] : opa[7];
		sb = wide ? bb[15] : bb[7];
		sr = wide ? res[15] : res[7];
		if (op <= `CRF_OP_SBC)
			v_out = (sa == sb) && (sr != sa); // RQ14
		n_out = sr; // RQ12 RQ19
		z_out = wide ? (res == 16'h0000) : (res[7:0] == 8'h00); // RQ13
		// extended result keeps the carry beyond the data path
		res_ext = {{(EXT_W-17){1'b0}}, c_out, res}; // RQ17
	end

endmodule

// File: verilog/crf_core.v
/*
 * programmer-visible register set of a 16-bit processor core: two byte
 * accumulators and their double view, two pointer registers, stack
 * pointer, program counter and condition flags, plus indexed address
 * formation and interrupt/stop gating from the mask bits.
 * assumes: instruction sequencer drives the control inputs; registers
 * are reached only through those inputs, never through memory.
 */
// Overview of operation
// RQ1 - two 8-bit accumulators hold operands, results
// RQ2 - double accumulator is high:low byte concatenation
// RQ3 - index base plus constant or accumulator offset
// RQ4 - stack pointer holds last used stack address
// RQ5 - program counter holds next instruction address
// RQ6 - pc usable as base except auto inc/dec
// RQ7 - stop-lock flag blocks halt instruction
// RQ8 - pin mask flag blocks high-priority request
// RQ9 - half-carry from bit 3 on byte adds
// RQ10 - decimal adjust uses half-carry and carry
// RQ11 - interrupt mask flag blocks maskable interrupts
// RQ12 - negative flag set when result below zero
// RQ13 - zero flag set when result all zero
// RQ14 - overflow flag on signed overflow
// RQ15 - carry flag on carry or borrow out
// RQ16 - at least three code bytes queued per instruction
// RQ17 - 16-bit paths, up to 20-bit intermediates
// RQ18 - registers reached only through instructions
// RQ19 - negative equals msb at operation width
`timescale 1ns/100ps
`include "crf_regs.vh"

module crf_core #(
	parameter QUEUE_MIN = `CRF_QUEUE_MIN,
	parameter EXT_W     = `CRF_EXT_W
) (
	// clock and reset
	input  wire             CLK,
	input  wire             RST,
	// register load / read
	input  wire             WR_EN,
	input  wire [2:0]       WR_SEL,
	input  wire [15:0]      WR_DATA,
	input  wire [2:0]       RD_SEL,
	output reg  [15:0]      RD_DATA,
	// alu operation on accumulators
	input  wire             ALU_EN,
	input  wire [2:0]       ALU_OP,
	input  wire             ALU_WIDE,
	input  wire [15:0]      ALU_OPB,
	output reg  [EXT_W-1:0] ALU_EXT,
	// stack push / pull by step
	input  wire             SP_PUSH,
	input  wire             SP_PULL,
	input  wire [2:0]       SP_STEP,
	// program counter advance and jump
	input  wire             PC_ADV,
	input  wire [1:0]       PC_STEP,
	input  wire             PC_JUMP,
	input  wire [15:0]      PC_TARGET,
	// indexed addressing
	input  wire             IDX_REQ,
	input  wire [1:0]       IDX_BASE,
	input  wire [1:0]       IDX_OFS_SEL,
	input  wire [15:0]      IDX_CONST,
	input  wire             IDX_AUTO,
	output reg  [15:0]      IDX_ADDR,
	output reg              IDX_ERR,
	// instruction queue fill level
	input  wire [2:0]       QUEUE_BYTES,
	output reg              QUEUE_READY,
	// interrupt and stop gating
	input  wire             HALT_REQ,
	input  wire             HP_REQ_N,
	input  wire             MASKABLE_REQ,
	output reg              HALT_GO,
	output reg              HP_TAKE,
	output reg              MASKABLE_TAKE,
	// flag view
	output reg  [7:0]       FLAGS
);

	// ----------------------------------------
	// registers
	// ----------------------------------------
	// data registers keep contents through reset, so no reset term
	reg [7:0]  acc_high_reg;
	reg [7:0]  acc_low_reg;
	reg [15:0] ptr_one_reg;
	reg [15:0] ptr_two_reg;
	reg [15:0] stack_reg;
	reg [15:0] pc_reg;
	reg [7:0]  flags_reg;

	reg [7:0]  flags_next;
	reg [15:0] base_val;
	reg [15:0] ofs_val;
	reg [15:0] rd_next;

	wire [15:0] dacc = {acc_high_reg, acc_low_reg}; // RQ2
	wire [15:0]      alu_res;
	wire [EXT_W-1:0] alu_ext;
	wire             alu_h;
	wire             alu_n;
	wire             alu_z;
	wire             alu_v;
	wire             alu_c;

	crf_alu #(
		.EXT_W (EXT_W)
	) u_alu (
		.op      (ALU_OP),
		.wide    (ALU_WIDE),
		.opa     (ALU_WIDE ? dacc : {8'h00, acc_high_reg}),
		.opb     (ALU_OPB),
		.c_in    (flags_reg[`CRF_F_CARRY]),
		.h_in    (flags_reg[`CRF_F_HALF]),
		.res     (alu_res),
		.res_ext (alu_ext),
		.h_out   (alu_h),
		.n_out   (alu_n),
		.z_out   (alu_z),
		.v_out   (alu_v),
		.c_out   (alu_c)
	);

	// ----------------------------------------
	// accumulators and double view
	// ----------------------------------------
	always @(posedge CLK) begin
		if (ALU_EN) begin
			if (ALU_WIDE)
				{acc_high_reg, acc_low_reg} <= alu_res; // RQ2
			else
				acc_high_reg <= alu_res[7:0]; // RQ1
		end else if (WR_EN) begin
			if (WR_SEL == `CRF_SEL_ACCH)
				acc_high_reg <= WR_DATA[7:0]; // RQ1
			if (WR_SEL == `CRF_SEL_ACCL)
				acc_low_reg <= WR_DATA[7:0]; // RQ1
			if (WR_SEL == `CRF_SEL_DACC)
				{acc_high_reg, acc_low_reg} <= WR_DATA; // RQ2
		end
	end

	// ----------------------------------------
	// pointer, stack and program counter
	// ----------------------------------------
	always @(posedge CLK) begin
		if (WR_EN && (WR_SEL == `CRF_SEL_PTR1))
			ptr_one_reg <= WR_DATA; // RQ3
		if (WR_EN && (WR_SEL == `CRF_SEL_PTR2))
			ptr_two_reg <= WR_DATA; // RQ3
		// pre-decrement push leaves sp on the last used address
		if (SP_PUSH)
			stack_reg <= stack_reg - {13'h0000, SP_STEP}; // RQ4
		else if (SP_PULL)
			stack_reg <= stack_reg + {13'h0000, SP_STEP}; // RQ4
		else if (WR_EN && (WR_SEL == `CRF_SEL_SP))
			stack_reg <= WR_DATA; // RQ4
		if (PC_JUMP)
			pc_reg <= PC_TARGET; // RQ5
		else if (PC_ADV)
			pc_reg <= pc_reg + {14'h0000, PC_STEP}; // RQ5
		else if (WR_EN && (WR_SEL == `CRF_SEL_PC))
			pc_reg <= WR_DATA; // RQ5
	end

	// ----------------------------------------
	// condition flags
	// ----------------------------------------
	always @* begin
		flags_next = flags_reg;
		if (ALU_EN) begin
			flags_next[`CRF_F_HALF]  = alu_h; // RQ9
			flags_next[`CRF_F_NEG]   = alu_n; // RQ12
			flags_next[`CRF_F_ZERO]  = alu_z; // RQ13
			flags_next[`CRF_F_OVF]   = alu_v; // RQ14
			flags_next[`CRF_F_CARRY] = alu_c; // RQ15
		end else if (WR_EN && (WR_SEL == `CRF_SEL_FLAGS)) begin
			flags_next = WR_DATA[7:0];
			// once cleared by software the pin mask cannot be set again
			if (!flags_reg[`CRF_F_HPMASK])
				flags_next[`CRF_F_HPMASK] = 1'b0;
		end
	end

	always @(posedge CLK or posedge RST) begin
		if (RST)
			flags_reg <= `CRF_FLAGS_RST;
		else
			flags_reg <= flags_next;
	end

	// ----------------------------------------
	// indexed address formation
	// ----------------------------------------
	always @* begin
		case (IDX_BASE)
		`CRF_BASE_P1: base_val = ptr_one_reg;
		`CRF_BASE_P2: base_val = ptr_two_reg;
		`CRF_BASE_SP: base_val = stack_reg;
		`CRF_BASE_PC: base_val = pc_reg; // RQ6
		default:      base_val = ptr_one_reg;
		endcase
		case (IDX_OFS_SEL)
		`CRF_OFS_CONST: ofs_val = IDX_CONST;
		`CRF_OFS_ACCH:  ofs_val = {8'h00, acc_high_reg};
		`CRF_OFS_ACCL:  ofs_val = {8'h00, acc_low_reg};
		`CRF_OFS_DACC:  ofs_val = dacc;
		default:        ofs_val = IDX_CONST;
		endcase
	end

	// ----------------------------------------
	// read port, outputs
	// ----------------------------------------
	always @* begin
		case (RD_SEL)
		`CRF_SEL_ACCH:  rd_next = {8'h00, acc_high_reg};
		`CRF_SEL_ACCL:  rd_next = {8'h00, acc_low_reg};
		`CRF_SEL_DACC:  rd_next = dacc;
		`CRF_SEL_PTR1:  rd_next = ptr_one_reg;
		`CRF_SEL_PTR2:  rd_next = ptr_two_reg;
		`CRF_SEL_SP:    rd_next = stack_reg;
		`CRF_SEL_PC:    rd_next = pc_reg;
		`CRF_SEL_FLAGS: rd_next = {8'h00, flags_reg};
		default:        rd_next = 16'h0000;
		endcase
	end

	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			RD_DATA       <= 16'h0000;
			ALU_EXT       <= {EXT_W{1'b0}};
			IDX_ADDR      <= 16'h0000;
			IDX_ERR       <= 1'b0;
			QUEUE_READY   <= 1'b0;
			HALT_GO       <= 1'b0;
			HP_TAKE       <= 1'b0;
			MASKABLE_TAKE <= 1'b0;
			FLAGS         <= `CRF_FLAGS_RST;
		end else begin
			RD_DATA <= rd_next; // RQ18
			if (ALU_EN)
				ALU_EXT <= alu_ext; // RQ17
			if (IDX_REQ) begin
				IDX_ADDR <= base_val + ofs_val; // RQ3
				IDX_ERR  <= IDX_AUTO &&
					(IDX_BASE == `CRF_BASE_PC); // RQ6
			end
			QUEUE_READY <= ({29'h0, QUEUE_BYTES} >= QUEUE_MIN); // RQ16
			HALT_GO <= HALT_REQ &&
				!flags_next[`CRF_F_STOPLOCK]; // RQ7
			HP_TAKE <= !HP_REQ_N &&
				!flags_next[`CRF_F_HPMASK]; // RQ8
			MASKABLE_TAKE <= MASKABLE_REQ &&
				!flags_next[`CRF_F_IMASK]; // RQ11
			FLAGS <= flags_next;
		end
	end

endmodule

// File: testbench/crf_core_checker.sv
/*
 * concurrent checks on the register file core ports.
 * assumes: bound into crf_core; one clock, async active-high reset.
 */
`timescale 1ns/100ps

module crf_core_checker #(
	parameter EXT_W = 20
) (
	// clock and reset
	input wire             CLK,
	input wire             RST,
	// alu
	input wire             ALU_EN,
	input wire             ALU_WIDE,
	input wire [EXT_W-1:0] ALU_EXT,
	// indexed addressing
	input wire             IDX_REQ,
	input wire [1:0]       IDX_BASE,
	input wire             IDX_AUTO,
	input wire             IDX_ERR,
	// queue, gating, flags
	input wire [2:0]       QUEUE_BYTES,
	input wire             QUEUE_READY,
	input wire             HALT_REQ,
	input wire             HP_REQ_N,
	input wire             MASKABLE_REQ,
	input wire             HALT_GO,
	input wire             HP_TAKE,
	input wire             MASKABLE_TAKE,
	input wire [7:0]       FLAGS
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);

	// ----------------------------------------
	// gates use the flags written at the same edge
	// ----------------------------------------
	a_halt_gate: assert property (
		!$past(RST) |-> HALT_GO == ($past(HALT_REQ) && !FLAGS[7]))
		else $error("halt gate wrong");
	a_pin_gate: assert property (
		!$past(RST) |-> HP_TAKE == (!$past(HP_REQ_N) && !FLAGS[6]))
		else $error("pin gate wrong");
	a_irq_gate: assert property (
		!$past(RST) |-> MASKABLE_TAKE == ($past(MASKABLE_REQ) && !FLAGS[4]))
		else $error("maskable gate wrong");
	a_queue_min: assert property (
		!$past(RST) |-> QUEUE_READY == ($past(QUEUE_BYTES) >= 3'h3))
		else $error("queue ready wrong");

	// ----------------------------------------
	// addressing and alu results
	// ----------------------------------------
	a_idx_pc_auto: assert property (
		IDX_REQ |=> IDX_ERR == ($past(IDX_AUTO) && $past(IDX_BASE) == 2'h3))
		else $error("index error flag wrong");
	a_neg_msb: assert property (
		ALU_EN |=> FLAGS[3] == ($past(ALU_WIDE) ? ALU_EXT[15] : ALU_EXT[7]))
		else $error("negative flag wrong");
	a_zero_all: assert property (
		ALU_EN |=> FLAGS[2] == ($past(ALU_WIDE) ? ALU_EXT[15:0] == 16'h0000
			: ALU_EXT[7:0] == 8'h00))
		else $error("zero flag wrong");
	a_ext_top: assert property (
		ALU_EN |=> ~|ALU_EXT[EXT_W-1:17])
		else $error("extended result top bits set");
endmodule

bind crf_core crf_core_checker #(.EXT_W(EXT_W)) chk (.CLK(CLK), .RST(RST),
	.ALU_EN(ALU_EN), .ALU_WIDE(ALU_WIDE), .ALU_EXT(ALU_EXT),
	.IDX_REQ(IDX_REQ), .IDX_BASE(IDX_BASE), .IDX_AUTO(IDX_AUTO),
	.IDX_ERR(IDX_ERR), .QUEUE_BYTES(QUEUE_BYTES), .QUEUE_READY(QUEUE_READY),
	.HALT_REQ(HALT_REQ), .HP_REQ_N(HP_REQ_N), .MASKABLE_REQ(MASKABLE_REQ),
	.HALT_GO(HALT_GO), .HP_TAKE(HP_TAKE), .MASKABLE_TAKE(MASKABLE_TAKE),
	.FLAGS(FLAGS));

// File: testbench/test_cpu_register_file_flags.sv
/*
 * self-checking bench for the processor register file core.
 * assumes: crf_core with default parameters, crf_regs.vh on the path.
 */
`timescale 1ns/100ps
`include "crf_regs.vh"
`define CHK(g, e) begin checks = checks + 1; if ((g) !== (e)) begin \
	n_errors = n_errors + 1; $display("ERROR %0t: got %h want %h", \
	$time, g, e); end end

module test_cpu_register_file_flags;
	reg         CLK, RST, WR_EN, ALU_EN, ALU_WIDE, SP_PUSH, SP_PULL;
	reg         PC_ADV, PC_JUMP, IDX_REQ, IDX_AUTO, HALT_REQ, HP_REQ_N;
	reg         MASKABLE_REQ;
	reg  [2:0]  WR_SEL, RD_SEL, ALU_OP, SP_STEP, QUEUE_BYTES;
	reg  [1:0]  PC_STEP, IDX_BASE, IDX_OFS_SEL;
	reg  [15:0] WR_DATA, ALU_OPB, PC_TARGET, IDX_CONST;
	wire [15:0] RD_DATA, IDX_ADDR;
	wire [19:0] ALU_EXT;
	wire [7:0]  FLAGS;
	wire        IDX_ERR, QUEUE_READY, HALT_GO, HP_TAKE, MASKABLE_TAKE;
	integer     n_errors, checks, i;

	crf_core uut (.CLK(CLK), .RST(RST), .WR_EN(WR_EN), .WR_SEL(WR_SEL),
		.WR_DATA(WR_DATA), .RD_SEL(RD_SEL), .RD_DATA(RD_DATA),
		.ALU_EN(ALU_EN), .ALU_OP(ALU_OP), .ALU_WIDE(ALU_WIDE),
		.ALU_OPB(ALU_OPB), .ALU_EXT(ALU_EXT), .SP_PUSH(SP_PUSH),
		.SP_PULL(SP_PULL), .SP_STEP(SP_STEP), .PC_ADV(PC_ADV),
		.PC_STEP(PC_STEP), .PC_JUMP(PC_JUMP), .PC_TARGET(PC_TARGET),
		.IDX_REQ(IDX_REQ), .IDX_BASE(IDX_BASE), .IDX_OFS_SEL(IDX_OFS_SEL),
		.IDX_CONST(IDX_CONST), .IDX_AUTO(IDX_AUTO), .IDX_ADDR(IDX_ADDR),
		.IDX_ERR(IDX_ERR), .QUEUE_BYTES(QUEUE_BYTES),
		.QUEUE_READY(QUEUE_READY), .HALT_REQ(HALT_REQ),
		.HP_REQ_N(HP_REQ_N), .MASKABLE_REQ(MASKABLE_REQ),
		.HALT_GO(HALT_GO), .HP_TAKE(HP_TAKE),
		.MASKABLE_TAKE(MASKABLE_TAKE), .FLAGS(FLAGS));

	always #5 CLK = ~CLK;

	// ----------------------------------------
	// register access, one request per call
	// ----------------------------------------
	task wr(input [2:0] s, input [15:0] d);
		@(posedge CLK) begin
			WR_EN <= 1'b1;
			WR_SEL <= s;
			WR_DATA <= d;
		end
		@(posedge CLK) WR_EN <= 1'b0;
	endtask

	// read data lands one edge after the selector is taken
	task rd(input [2:0] s, input [15:0] e);
		@(posedge CLK) RD_SEL <= s;
		@(posedge CLK) #1;
		`CHK(RD_DATA, e)
	endtask

	task alu(input [2:0] o, input w, input [15:0] b, input [7:0] m, e);
		@(posedge CLK) begin
			ALU_EN <= 1'b1;
			ALU_OP <= o;
			ALU_WIDE <= w;
			ALU_OPB <= b;
		end
		@(posedge CLK) ALU_EN <= 1'b0;
		#1;
		`CHK(FLAGS & m, e)
	endtask

	// address is formed but not checked when the form is refused
	task idx(input [1:0] b, o, input [15:0] c, input au, input [15:0] a);
		@(posedge CLK) begin
			IDX_REQ <= 1'b1;
			IDX_BASE <= b;
			IDX_OFS_SEL <= o;
			IDX_CONST <= c;
			IDX_AUTO <= au;
		end
		@(posedge CLK) IDX_REQ <= 1'b0;
		#1;
		`CHK(IDX_ERR, au && b == `CRF_BASE_PC)
		if (!(au && b == `CRF_BASE_PC)) `CHK(IDX_ADDR, a)
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_gates;
		`CHK(FLAGS, 8'hd0)
		@(posedge CLK) begin
			HALT_REQ <= 1'b1;
			HP_REQ_N <= 1'b0;
			MASKABLE_REQ <= 1'b1;
			QUEUE_BYTES <= 3'h2;
		end
		@(posedge CLK) #1;
		`CHK({HALT_GO, HP_TAKE, MASKABLE_TAKE}, 3'b000)
		`CHK(QUEUE_READY, 1'b0)
		wr(`CRF_SEL_FLAGS, 16'h0000);
		QUEUE_BYTES <= 3'h3;
		#1;
		`CHK({HALT_GO, HP_TAKE, MASKABLE_TAKE}, 3'b111)
		// pin mask cannot be set again by a write
		wr(`CRF_SEL_FLAGS, 16'h00d0);
		HALT_REQ <= 1'b0;
		HP_REQ_N <= 1'b1;
		MASKABLE_REQ <= 1'b0;
		#1;
		`CHK({FLAGS, HALT_GO, HP_TAKE, MASKABLE_TAKE}, 11'h482)
		`CHK(QUEUE_READY, 1'b1)
		wr(`CRF_SEL_FLAGS, 16'h0000);
		$display("gates test done");
	endtask

	task t_regs;
		for (i = 3; i < 7; i = i + 1) begin
			wr(i[2:0], {i[3:0] - 4'h2, 12'h000});
			rd(i[2:0], {i[3:0] - 4'h2, 12'h000});
		end
		wr(`CRF_SEL_DACC, 16'h1234);
		rd(`CRF_SEL_ACCH, 16'h0012);
		wr(`CRF_SEL_DACC, 16'h5678);
		rd(`CRF_SEL_ACCL, 16'h0078);
		wr(`CRF_SEL_ACCL, 16'h00cd);
		rd(`CRF_SEL_DACC, 16'h56cd);
		$display("register test done");
	endtask

	task t_alu;
		wr(`CRF_SEL_ACCH, 16'h0008);
		alu(`CRF_OP_ADD, 1'b0, 16'h0008, 8'hff, 8'h20);
		rd(`CRF_SEL_ACCH, 16'h0010);
		wr(`CRF_SEL_ACCH, 16'h0080);
		alu(`CRF_OP_ADD, 1'b0, 16'h0080, 8'hff, 8'h07);
		`CHK(ALU_EXT, 20'h10000)
		alu(`CRF_OP_SUB, 1'b0, 16'h0001, 8'hff, 8'h09);
		alu(`CRF_OP_ADC, 1'b0, 16'h0000, 8'hff, 8'h25);
		wr(`CRF_SEL_ACCH, 16'h0009);
		alu(`CRF_OP_ADD, 1'b0, 16'h0008, 8'hff, 8'h20);
		alu(`CRF_OP_DAA, 1'b0, 16'h0000, 8'h0f, 8'h00);
		rd(`CRF_SEL_ACCH, 16'h0017);
		// upper nibble correction and decimal carry out
		wr(`CRF_SEL_ACCH, 16'h0099);
		alu(`CRF_OP_ADD, 1'b0, 16'h0001, 8'hff, 8'h08);
		alu(`CRF_OP_DAA, 1'b0, 16'h0000, 8'h0f, 8'h05);
		rd(`CRF_SEL_ACCH, 16'h0000);
		alu(`CRF_OP_PASS, 1'b1, 16'h8000, 8'h0e, 8'h08);
		alu(`CRF_OP_SUB, 1'b1, 16'h0001, 8'h0f, 8'h02);
		alu(`CRF_OP_SBC, 1'b1, 16'h7fff, 8'h0f, 8'h04);
		`CHK(ALU_EXT, 20'h00000)
		$display("alu test done");
	endtask

	task t_idx;
		wr(`CRF_SEL_DACC, 16'h0102);
		idx(`CRF_BASE_P1, `CRF_OFS_CONST, 16'h0010, 1'b0, 16'h1010);
		idx(`CRF_BASE_P2, `CRF_OFS_ACCH, 16'h0000, 1'b0, 16'h2001);
		idx(`CRF_BASE_SP, `CRF_OFS_ACCL, 16'h0000, 1'b0, 16'h3002);
		idx(`CRF_BASE_PC, `CRF_OFS_DACC, 16'h0000, 1'b0, 16'h4102);
		idx(`CRF_BASE_PC, `CRF_OFS_CONST, 16'hfff0, 1'b0, 16'h3ff0);
		idx(`CRF_BASE_P1, `CRF_OFS_CONST, 16'h0001, 1'b1, 16'h1001);
		idx(`CRF_BASE_PC, `CRF_OFS_CONST, 16'h0001, 1'b1, 16'h0000);
		$display("index test done");
	endtask

	// jump outranks advance in the same cycle
	task t_move;
		@(posedge CLK) begin
			SP_PUSH <= 1'b1;
			SP_STEP <= 3'h2;
			PC_JUMP <= 1'b1;
			PC_TARGET <= 16'h5a5a;
			PC_ADV <= 1'b1;
			PC_STEP <= 2'h3;
		end
		@(posedge CLK) begin
			SP_PUSH <= 1'b0;
			SP_PULL <= 1'b1;
			SP_STEP <= 3'h7;
			PC_JUMP <= 1'b0;
		end
		@(posedge CLK) begin
			SP_PULL <= 1'b0;
			PC_ADV <= 1'b0;
		end
		rd(`CRF_SEL_SP, 16'h3005);
		rd(`CRF_SEL_PC, 16'h5a5d);
		$display("stack and pc test done");
	endtask

	// reset held two edges so no gate check straddles the pulse
	task t_reset;
		wr(`CRF_SEL_DACC, 16'hbeef);
		@(posedge CLK) begin
			RST <= 1'b1;
			QUEUE_BYTES <= 3'h0;
		end
		repeat (2) @(posedge CLK);
		RST <= 1'b0;
		#1;
		`CHK({FLAGS, RD_DATA}, {`CRF_FLAGS_RST, 16'h0000})
		// data registers keep their contents through reset
		rd(`CRF_SEL_DACC, 16'hbeef);
		$display("reset test done");
	endtask

	task give_verdict;
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		CLK = 1'b0;
		RST = 1'b1;
		HP_REQ_N = 1'b1;
		{WR_EN, ALU_EN, ALU_WIDE, SP_PUSH, SP_PULL, PC_ADV, PC_JUMP,
			IDX_REQ, IDX_AUTO, HALT_REQ, MASKABLE_REQ, WR_SEL, RD_SEL,
			ALU_OP, SP_STEP, QUEUE_BYTES, PC_STEP, IDX_BASE, IDX_OFS_SEL,
			WR_DATA, ALU_OPB, PC_TARGET, IDX_CONST} = '0;
		n_errors = 0;
		checks = 0;
		repeat (10) @(posedge CLK);
		RST <= 1'b0;
		t_gates;
		t_regs;
		t_alu;
		t_idx;
		t_move;
		t_reset;
		give_verdict;
	end

	// hang guard
	initial begin
		#100000;
		n_errors = n_errors + 1;
		$display("ERROR %0t: run did not finish", $time);
		give_verdict;
	end
endmodule
